// ==== common/mfp_params.svh ====
// constants of the multi-function pin setup and parameter store
// assumes inclusion by bare name from package and design files
`ifndef MFP_PARAMS_SVH
`define MFP_PARAMS_SVH

// command codes
`define MFP_CMD_SETUP 8'hF9
`define MFP_CMD_STORE_DEFAULT 8'h11
`define MFP_CMD_RESTORE_DEFAULT 8'h12
`define MFP_CMD_STORE_USER 8'h15
`define MFP_CMD_RESTORE_USER 8'h16

// setup byte fields
`define MFP_BIT_PULL 0
`define MFP_BIT_DROOP_FIX 1
`define MFP_BIT_OK_EN 2
`define MFP_BIT_OK_HIZ 5
`define MFP_MODE_HI 7
`define MFP_MODE_LO 6
`define MFP_MODE_STANDALONE 2'h0
`define MFP_MODE_DROOP 2'h2

// factory values of the setup byte
`define MFP_DEF_STANDALONE 8'h04
`define MFP_DEF_DROOP 8'h86

// legal setup codes in droop load share mode
`define MFP_DROOP_CODE0 8'h82
`define MFP_DROOP_CODE1 8'h83
`define MFP_DROOP_CODE2 8'h86
`define MFP_DROOP_CODE3 8'h87
`define MFP_DROOP_CODE4 8'hA6
`define MFP_DROOP_CODE5 8'hA7

`endif

// ==== common/mfp_pkg.sv ====
// types of the multi-function pin setup and parameter store
// assumes mfp_params.svh is on the include path
`include "mfp_params.svh"

package mfp_pkg;

    typedef enum logic [1:0] {
        cmd_write_byte,
        cmd_read_byte,
        cmd_send_byte
    } mfp_kind_type;

    typedef struct packed {
        mfp_kind_type kind;
        logic [7:0] code;
        logic [7:0] data;
        logic pec_ok;
    } mfp_cmd_type;

    typedef struct packed {
        logic ack;
        logic err;
        logic [7:0] data;
    } mfp_rsp_type;

    typedef enum {st_boot, st_run, st_save} mfp_state_type;

endpackage : mfp_pkg

// ==== rtl/mfp_config_loader.sv ====
// setup byte register, pin function control and user/factory set loader
// assumes a bus engine that decodes transactions and checks the pec byte,
// and a non-volatile store that keeps the user set across power cycles
`timescale 1ns/10ps
`default_nettype none
`include "mfp_params.svh"

module mfp_config_loader
    import mfp_pkg::*;
#(
    parameter bit DROOP_VARIANT = 1'b0
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire mfp_cmd_type i_cmd,
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    output mfp_rsp_type o_rsp,
    input wire logic i_user_valid,
    input wire logic [7:0] i_user_data,
    output logic o_store_valid,
    output logic [7:0] o_store_data,
    input wire logic i_store_done,
    input wire logic i_output_ok_status,
    input wire logic i_remote_active_low,
    output logic o_remote_pull_up_en,
    output logic o_remote_pull_down_en,
    output logic o_output_ok_out,
    output logic o_output_ok_oe,
    output logic o_droop_mode,
    output logic [7:0] o_setup
);

    localparam logic [7:0] FACTORY_SETUP =
        DROOP_VARIANT ? `MFP_DEF_DROOP : `MFP_DEF_STANDALONE;

    function automatic logic setup_legal(input logic [7:0] value);
        logic [1:0] mode;
        mode = value[`MFP_MODE_HI:`MFP_MODE_LO];
        if (mode == `MFP_MODE_STANDALONE) begin
            setup_legal = 1'b1;
        end else if (mode == `MFP_MODE_DROOP) begin
            setup_legal = (value == `MFP_DROOP_CODE0) ||
                          (value == `MFP_DROOP_CODE1) ||
                          (value == `MFP_DROOP_CODE2) ||
                          (value == `MFP_DROOP_CODE3) ||
                          (value == `MFP_DROOP_CODE4) ||
                          (value == `MFP_DROOP_CODE5);
        end else begin
            setup_legal = 1'b0;
        end
    endfunction : setup_legal

    mfp_state_type state_reg;
    mfp_state_type state_next;
    logic [7:0] setup_reg;
    logic [7:0] setup_next;
    logic [7:0] store_data_reg;
    mfp_rsp_type rsp_reg;
    mfp_rsp_type rsp_next;
    logic pull_up_reg;
    logic pull_down_reg;
    logic ok_out_reg;
    logic ok_oe_reg;

    // command decode
    wire take = i_cmd_valid && (state_reg == st_run);
    wire is_write = i_cmd.kind == cmd_write_byte;
    wire is_read = i_cmd.kind == cmd_read_byte;
    wire is_send = i_cmd.kind == cmd_send_byte;
    wire is_setup = i_cmd.code == `MFP_CMD_SETUP;
    wire send_ok = take && is_send && i_cmd.pec_ok;
    wire setup_wr = take && is_write && is_setup &&
                    setup_legal(i_cmd.data);
    wire setup_rd = take && is_read && is_setup;
    wire store_user = send_ok &&
                      (i_cmd.code == `MFP_CMD_STORE_USER);
    wire restore_user = send_ok && i_user_valid &&
                        (i_cmd.code == `MFP_CMD_RESTORE_USER);
    wire restore_dflt = send_ok &&
                        (i_cmd.code == `MFP_CMD_RESTORE_DEFAULT);
    // store-default is never in the good set: refused, no effect
    wire cmd_good = setup_wr || setup_rd || store_user ||
                    restore_user || restore_dflt;
    wire save_end = (state_reg == st_save) && i_store_done;

    // pin function decode from the working copy; bits 3, 4 unused
    wire pull_en = setup_reg[`MFP_BIT_PULL];
    wire ok_en = setup_reg[`MFP_BIT_OK_EN];
    wire ok_hiz = setup_reg[`MFP_BIT_OK_HIZ];
    wire pull_up_next = pull_en && i_remote_active_low;
    wire pull_down_next = pull_en && !i_remote_active_low;
    // push-pull drives active low; float mode releases when good
    wire ok_oe_next = ok_en &&
                      !(ok_hiz && i_output_ok_status);
    wire ok_out_next = !i_output_ok_status;

    always_comb begin
        state_next = state_reg;
        setup_next = setup_reg;
        unique case (state_reg)
            st_boot: begin
                // empty user area falls back to factory set
                setup_next = i_user_valid ? i_user_data
                                          : FACTORY_SETUP;
                state_next = st_run;
            end
            st_run: begin
                if (setup_wr) begin
                    setup_next = i_cmd.data;
                end else if (restore_user) begin
                    setup_next = i_user_data;
                end else if (restore_dflt) begin
                    setup_next = FACTORY_SETUP;
                end
                if (store_user) begin
                    state_next = st_save;
                end
            end
            st_save: begin
                if (i_store_done) begin
                    state_next = st_run;
                end
            end
        endcase
    end

    always_comb begin
        rsp_next.ack = (take && !store_user) || save_end;
        rsp_next.err = take && !cmd_good;
        rsp_next.data = setup_rd ? setup_reg : 8'h00;
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= st_boot;
            setup_reg <= `MFP_DEF_STANDALONE;
            rsp_reg <= '0;
        end else begin
            state_reg <= state_next;
            setup_reg <= setup_next;
            rsp_reg <= rsp_next;
        end
    end

    // snapshot taken at the command, held for the whole save
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            store_data_reg <= 8'h00;
        end else if (store_user) begin
            store_data_reg <= setup_reg;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            pull_up_reg <= 1'b0;
            pull_down_reg <= 1'b0;
            ok_out_reg <= 1'b1;
            ok_oe_reg <= 1'b0;
        end else begin
            pull_up_reg <= pull_up_next;
            pull_down_reg <= pull_down_next;
            ok_out_reg <= ok_out_next;
            ok_oe_reg <= ok_oe_next;
        end
    end

    assign o_cmd_ready = state_reg == st_run;
    assign o_rsp = rsp_reg;
    assign o_store_valid = state_reg == st_save;
    assign o_store_data = store_data_reg;
    assign o_remote_pull_up_en = pull_up_reg;
    assign o_remote_pull_down_en = pull_down_reg;
    assign o_output_ok_out = ok_out_reg;
    assign o_output_ok_oe = ok_oe_reg;
    assign o_droop_mode =
        setup_reg[`MFP_MODE_HI:`MFP_MODE_LO] == `MFP_MODE_DROOP;
    assign o_setup = setup_reg;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    property p_setup_write;
        setup_wr |=> (setup_reg == $past(i_cmd.data)) && o_rsp.ack
            && !o_rsp.err;
    endproperty
    a_setup_write: assert property (p_setup_write)
        else $error("setup write not applied");

    property p_setup_read;
        setup_rd && !setup_wr |=> o_rsp.ack
            && (o_rsp.data == $past(setup_reg));
    endproperty
    a_setup_read: assert property (p_setup_read)
        else $error("setup read returned wrong value");

    property p_boot_user;
        (state_reg == st_boot) && i_user_valid
            |=> (setup_reg == $past(i_user_data)) && o_cmd_ready;
    endproperty
    a_boot_user: assert property (p_boot_user)
        else $error("user set not loaded at boot");

    property p_boot_factory;
        (state_reg == st_boot) && !i_user_valid
            |=> setup_reg == FACTORY_SETUP;
    endproperty
    a_boot_factory: assert property (p_boot_factory)
        else $error("factory set not loaded at boot");

    property p_store_default;
        take && is_send && (i_cmd.code == `MFP_CMD_STORE_DEFAULT)
            |=> o_rsp.err && $stable(setup_reg) && !o_store_valid;
    endproperty
    a_store_default: assert property (p_store_default)
        else $error("store-default was not refused");

    property p_store_user;
        store_user |=> o_store_valid && !o_cmd_ready
            && (o_store_data == $past(setup_reg));
    endproperty
    a_store_user: assert property (p_store_user)
        else $error("user save did not hold working value");

    property p_store_hold;
        o_store_valid && !i_store_done
            |=> o_store_valid && $stable(o_store_data);
    endproperty
    a_store_hold: assert property (p_store_hold)
        else $error("save ended or data moved before store finished");

    property p_save_done;
        o_store_valid && i_store_done
            |=> !o_store_valid && o_cmd_ready && o_rsp.ack && !o_rsp.err;
    endproperty
    a_save_done: assert property (p_save_done)
        else $error("save not closed after store finished");

    property p_restore_user;
        restore_user |=> (setup_reg == $past(i_user_data)) && o_rsp.ack
            && !o_rsp.err;
    endproperty
    a_restore_user: assert property (p_restore_user)
        else $error("stored user set not restored");

    property p_pec;
        take && is_send && !i_cmd.pec_ok
            |=> o_rsp.err && $stable(setup_reg) && o_cmd_ready;
    endproperty
    a_pec: assert property (p_pec)
        else $error("send byte without pec accepted");

    property p_bad_mode;
        take && is_write && is_setup
            && !setup_legal(i_cmd.data)
            |=> o_rsp.err && $stable(setup_reg);
    endproperty
    a_bad_mode: assert property (p_bad_mode)
        else $error("unsupported setup code accepted");

    property p_float;
        ok_en && ok_hiz && i_output_ok_status |=> !o_output_ok_oe;
    endproperty
    a_float: assert property (p_float)
        else $error("output-ok pin driven while asserted");

    property p_push_pull;
        ok_en && !ok_hiz |=> o_output_ok_oe
            && (o_output_ok_out == !$past(i_output_ok_status));
    endproperty
    a_push_pull: assert property (p_push_pull)
        else $error("output-ok push-pull level wrong");

    property p_pull;
        pull_en |=> (o_remote_pull_up_en == $past(i_remote_active_low))
            && (o_remote_pull_down_en != o_remote_pull_up_en);
    endproperty
    a_pull: assert property (p_pull)
        else $error("remote input pull direction wrong");

endmodule : mfp_config_loader
`default_nettype wire

// ==== verif/mfp_user_store_model.sv ====
// non-volatile user area model for the setup loader
// assumes save requests follow the loader's store handshake
`timescale 1ns/10ps
`default_nettype none
module mfp_user_store_model #(
    parameter int DELAY = 3
) (
    input wire logic i_core_clk,
    input wire logic i_store_valid,
    input wire logic [7:0] i_store_data,
    output logic o_store_done,
    output logic o_user_valid,
    output logic [7:0] o_user_data
);
    int cnt = 0;
    logic done_reg = 1'b0;
    // empty as delivered, junk data behind it
    logic full_reg = 1'b0;
    logic [7:0] data_reg = 8'h5A;
    wire hit = i_store_valid && !done_reg && (cnt == DELAY);
    // slow write, then keep the set across resets
    always @(posedge i_core_clk) begin
        done_reg <= hit;
        if (hit) begin
            full_reg <= 1'b1;
            data_reg <= i_store_data;
            cnt <= 0;
        end else if (i_store_valid && !done_reg) begin
            cnt <= cnt + 1;
        end
    end
    assign o_store_done = done_reg;
    assign o_user_valid = full_reg;
    assign o_user_data = data_reg;
endmodule : mfp_user_store_model
`default_nettype wire

// ==== verif/tb_mfp_config_loader.sv ====
// self-checking bench for the setup byte loader
// assumes the store model stands on the non-volatile side
`timescale 1ns/10ps
`default_nettype none
module tb_mfp_config_loader;
    import mfp_pkg::*;
    logic clk = 0, rst = 1, vld = 0, st = 1, alo = 1;
    mfp_cmd_type cmd = '0;
    mfp_rsp_type rsp;
    logic rdy, sv, sd, uv, pu, pd, ok_o, ok_oe, droop;
    logic [7:0] sdat, udat, setup;
    int num_errors = 0, compares = 0, cyc = 0;
    always #5 clk = ~clk;
    mfp_config_loader mfp_config_loader_inst (.i_core_clk(clk),
        .i_reset(rst), .i_cmd(cmd), .i_cmd_valid(vld), .o_cmd_ready(rdy),
        .o_rsp(rsp), .i_user_valid(uv), .i_user_data(udat),
        .o_store_valid(sv), .o_store_data(sdat), .i_store_done(sd),
        .i_output_ok_status(st), .i_remote_active_low(alo),
        .o_remote_pull_up_en(pu), .o_remote_pull_down_en(pd),
        .o_output_ok_out(ok_o), .o_output_ok_oe(ok_oe),
        .o_droop_mode(droop), .o_setup(setup));
    mfp_user_store_model mfp_user_store_model_inst (.i_core_clk(clk),
        .i_store_valid(sv), .i_store_data(sdat), .o_store_done(sd),
        .o_user_valid(uv), .o_user_data(udat));
    task automatic finish_test();
        if (num_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            $display("MISMATCH %0t timeout", $time);
            finish_test();
        end
    end
    task automatic chk(input logic [7:0] got, exp, input string m);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // one transaction, wait for the answer
    task automatic op(input mfp_kind_type k, input logic [7:0] c, d,
            input logic p, e);
        int n;
        n = 0;
        // one idle edge keeps back-to-back strobes apart
        @(posedge clk);
        #1 cmd = '{k, c, d, p};
        vld = 1'b1;
        @(posedge clk);
        #1 vld = 1'b0;
        while (rsp.ack !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1 n++;
        end
        chk({7'h00, rsp.ack}, 8'h01, "no answer");
        chk({7'h00, rsp.err}, {7'h00, e}, "refusal");
    endtask : op
    task automatic boot();
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({5'h00, rdy, sv, rsp.ack}, 8'h00, "reset");
        rst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : boot
    task automatic t_boot();
        chk(setup, 8'h04, "factory load");
        chk({6'h00, ok_oe, ok_o}, 8'h02, "ok pin");
        chk({7'h00, rdy}, 8'h01, "ready");
    endtask : t_boot
    // every droop code taken, unsupported ones refused
    task automatic t_modes();
        logic [7:0] good[6] = '{8'h82, 8'h83, 8'h86, 8'h87, 8'hA6, 8'hA7};
        logic [7:0] bad[4] = '{8'hC0, 8'h40, 8'h80, 8'hA4};
        foreach (good[i]) begin
            op(cmd_write_byte, 8'hF9, good[i], 1'b1, 1'b0);
            chk(setup, good[i], "write");
            chk({7'h00, droop}, 8'h01, "droop");
            op(cmd_read_byte, 8'hF9, 8'h00, 1'b1, 1'b0);
            chk(rsp.data, good[i], "read");
        end
        foreach (bad[i]) begin
            op(cmd_write_byte, 8'hF9, bad[i], 1'b1, 1'b1);
            chk(setup, 8'hA7, "kept");
        end
    endtask : t_modes
    // pin functions from setup byte, status and polarity
    task automatic t_pins();
        logic [7:0] c[7] = '{8'h01, 8'h01, 8'h18, 8'h04, 8'h04, 8'h24, 8'h24};
        logic [6:0] lo = 7'b1111101, gd = 7'b1010101;
        logic [7:0] e;
        for (int i = 0; i < 7; i++) begin
            op(cmd_write_byte, 8'hF9, c[i], 1'b1, 1'b0);
            alo = lo[i];
            st = gd[i];
            repeat (2) @(posedge clk);
            #1 e = {5'h00, c[i][0] & alo, c[i][0] & !alo,
                c[i][2] & !(c[i][5] & st)};
            chk({5'h00, pu, pd, ok_oe}, e, "pins");
            if (e[0]) chk({7'h00, ok_o}, {7'h00, !st}, "ok level");
            chk(setup, c[i], "stored");
        end
    endtask : t_pins
    task automatic t_refuse();
        op(cmd_send_byte, 8'h11, 8'h00, 1'b1, 1'b1);
        chk({7'h00, sv}, 8'h00, "no save");
        op(cmd_send_byte, 8'h15, 8'h00, 1'b0, 1'b1);
        chk({7'h00, uv}, 8'h00, "no store");
        op(cmd_send_byte, 8'h16, 8'h00, 1'b1, 1'b1);
        boot();
        chk(setup, 8'h04, "lost");
    endtask : t_refuse
    task automatic t_save();
        op(cmd_write_byte, 8'hF9, 8'h25, 1'b1, 1'b0);
        op(cmd_send_byte, 8'h15, 8'h00, 1'b1, 1'b0);
        chk(udat, 8'h25, "saved");
        op(cmd_write_byte, 8'hF9, 8'h00, 1'b1, 1'b0);
        boot();
        chk(setup, 8'h25, "user load");
        op(cmd_send_byte, 8'h12, 8'h00, 1'b1, 1'b0);
        chk(setup, 8'h04, "restore factory");
        op(cmd_send_byte, 8'h16, 8'h00, 1'b1, 1'b0);
        chk(setup, 8'h25, "restore user");
    endtask : t_save
    initial begin
        boot();
        t_boot();
        t_modes();
        t_pins();
        t_refuse();
        t_save();
        finish_test();
    end
endmodule : tb_mfp_config_loader
`default_nettype wire
